// >>> hdl/adcc_cfg.svh
// adcc register map, field positions and reset values
// assumes inclusion once per design file, before the package import
// Contract
// - per-converter digital enable bits 18..16
// - reference select field bits 15..13 picks pair
// - 64-pin: early bits 19..34 absent
// - 64/100-pin: early bits 35..42 absent
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

`define ADCC_OFF_CTRL3 16'h0010
`define ADCC_OFF_INTSTAT 16'h0020
`define ADCC_OFF_INTMASK 16'h0024
`define ADCC_OFF_TRGSNS 16'h00D0
`define ADCC_OFF_TIME0 16'h00D4
`define ADCC_OFF_TIME1 16'h00D8
`define ADCC_OFF_TIME2 16'h00DC
`define ADCC_OFF_ANCON 16'h0100
`define ADCC_OFF_CMP4 16'h30AC
`define ADCC_OFF_CMP5 16'h30B0
`define ADCC_OFF_CMP6 16'h30B4
`define ADCC_OFF_FSTAT 16'h30B8
`define ADCC_OFF_EIEN1 16'h30F0
`define ADCC_OFF_EIEN2 16'h30F4
`define ADCC_OFF_EISTAT1 16'h30F8
`define ADCC_OFF_CAL0 16'h3180
`define ADCC_OFF_CAL1 16'h3184
`define ADCC_OFF_FIFO 16'h80BC
`define ADCC_OFF_BASE 16'h80C0
`define ADCC_OFF_TIME3 16'h80E0
`define ADCC_OFF_TIME4 16'h80E4
`define ADCC_OFF_EISTAT2 16'hB0FC

`define ADCC_MASK_CTRL3 32'h0007E000
`define ADCC_MASK_TRGSNS 32'h00000FFF
`define ADCC_MASK_TIME 32'h1F7F03FF
`define ADCC_MASK_ANCON 32'h0F9F009F
`define ADCC_MASK_CMP 32'h00001FDF
`define ADCC_MASK_FSTAT 32'h9F800000
`define ADCC_MASK_BASE 32'h0000FFFF
`define ADCC_RESET_WORD 32'h00000000

`define ADCC_DIGEN_LSB 16
`define ADCC_DIGEN_MSB 18
`define ADCC_REFSEL_LSB 13
`define ADCC_REFSEL_MSB 15
`define ADCC_FEN_BIT 31
`define ADCC_ADCEN_LSB 24

`define ADCC_EI_ALL 45'h1FFFFFFFFFFF
`define ADCC_EI_ABSENT_64 45'h0007FFF80000
`define ADCC_EI_ABSENT_100 45'h07F800000000
`define ADCC_EI_HI_WIDTH 13
`define ADCC_INT_WIDTH 5
`define ADCC_HSIZE_WORD 3'h2

`endif

// >>> hdl/adcc_pkg.sv
// adcc shared types
// assumes adcc_cfg.svh holds all numeric constants
package adcc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} adcc_bus_state_t;
	typedef logic [31:0] adcc_word_t;
endpackage

// >>> hdl/adcc_ahb_slave.sv
// adcc AHB-Lite slave front end: one wait state on every word-sized transfer
// assumes the register file answers reg_rdata combinationally from reg_addr
`include "adcc_cfg.svh"
module adcc_ahb_slave
	import adcc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [15:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [15:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata
);
	adcc_bus_state_t state_q;
	logic write_q;
	// the wait state lets read data and clear-on-read come from one flop stage
	wire accept = hsel & hready & htrans[1] & (hsize == `ADCC_HSIZE_WORD);
	wire in_wait = (state_q == ST_WAIT);

	assign reg_wr = in_wait & write_q;
	assign reg_rd = in_wait & ~write_q;
	assign reg_wdata = hwdata;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			write_q <= 1'b0;
			reg_addr <= 16'h0000;
			hreadyout <= 1'b1;
			hrdata <= `ADCC_RESET_WORD;
			hresp <= 1'b0;
		end else begin
			case (state_q)
				ST_WAIT: begin
					state_q <= ST_DONE;
					hreadyout <= 1'b1;
					hrdata <= write_q ? `ADCC_RESET_WORD : reg_rdata;
				end
				default: begin
					if (accept) begin
						state_q <= ST_WAIT;
						write_q <= hwrite;
						reg_addr <= haddr;
						hreadyout <= 1'b0;
					end else begin
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence accepted_s;
		accept && hreadyout;
	endsequence
	one_wait_state_a: assert property (accepted_s |=> !hreadyout ##1 hreadyout)
		else $error("bus answer not after exactly one wait state");
endmodule

// >>> hdl/adcc_lane.sv
// adcc per-converter trigger and gating lane
// assumes trig_pin is asynchronous, res_valid and ei_pulse are on mclk
`include "adcc_cfg.svh"
module adcc_lane
	import adcc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic level_mode,
	input wire logic trig_pin,
	input wire logic res_valid,
	input wire logic ei_pulse,
	output logic start_q,
	output logic res_ok,
	output logic ei_ok
);
	logic [2:0] sync_q;
	logic trig_q;
	// only the second and third stages are compared; the first may be metastable
	wire agree = (sync_q[1] == sync_q[2]);
	wire trig_d = agree ? sync_q[2] : trig_q;
	wire fire = level_mode ? trig_d : (trig_d & ~trig_q);

	assign res_ok = res_valid & enable;
	assign ei_ok = ei_pulse & enable;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sync_q <= 3'h0;
			trig_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			sync_q <= {sync_q[1:0], trig_pin};
			trig_q <= trig_d;
			start_q <= fire & enable;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	start_needs_enable_a: assert property (start_q |-> $past(enable))
		else $error("start issued while converter digitally disabled");
endmodule

// >>> hdl/adcc_top.sv
// adcc converter control register block with AHB-Lite access
// assumes analog cores on mclk for results and early pulses; trigger pins asynchronous
`include "adcc_cfg.svh"
module adcc_top
	import adcc_pkg::*;
#(
	parameter int PINS = 144
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [15:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [2:0] trig_pin,
	input wire logic [2:0] result_valid,
	input wire logic [31:0] result_data,
	input wire logic [44:0] ei_pulse,
	output logic [2:0] converter_digital_enable,
	output logic [2:0] reference_select,
	output logic [2:0] conv_start,
	output logic [31:0] cal_word0,
	output logic [31:0] cal_word1,
	output logic irq
);
	localparam logic [44:0] EI_MASK = `ADCC_EI_ALL
		& ~((PINS == 64) ? `ADCC_EI_ABSENT_64 : 45'h000000000000)
		& ~((PINS == 64 || PINS == 100) ? `ADCC_EI_ABSENT_100 : 45'h000000000000);

	logic [15:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;

	logic [31:0] ctrl3_q;
	logic [31:0] trgsns_q;
	logic [31:0] time_q [5];
	logic [31:0] ancon_q;
	logic [31:0] cmp_q [3];
	logic [31:0] fstat_q;
	logic [31:0] base_q;
	logic [31:0] fifo_q;
	logic [2:0] fid_q;
	logic frdy_q;
	logic ovf_q;
	logic [44:0] early_interrupt_enable_bit_q;
	logic [44:0] eistat_q;
	logic [`ADCC_INT_WIDTH-1:0] intstat_q;
	logic [`ADCC_INT_WIDTH-1:0] intmask_q;

	logic [2:0] res_ok;
	logic [2:0] ei_ok;

	adcc_ahb_slave u_bus (
		.mclk(mclk),
		.reset_n(reset_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_lane
			adcc_lane u_lane (
				.mclk(mclk),
				.reset_n(reset_n),
				.enable(converter_digital_enable[gi]),
				.level_mode(trgsns_q[gi]),
				.trig_pin(trig_pin[gi]),
				.res_valid(result_valid[gi]),
				.ei_pulse(ei_pulse[gi]),
				.start_q(conv_start[gi]),
				.res_ok(res_ok[gi]),
				.ei_ok(ei_ok[gi])
			);
		end
	endgenerate

	wire sel_ctrl3 = (reg_addr == `ADCC_OFF_CTRL3);
	wire sel_intstat = (reg_addr == `ADCC_OFF_INTSTAT);
	wire sel_intmask = (reg_addr == `ADCC_OFF_INTMASK);
	wire sel_trgsns = (reg_addr == `ADCC_OFF_TRGSNS);
	wire sel_ancon = (reg_addr == `ADCC_OFF_ANCON);
	wire sel_fstat = (reg_addr == `ADCC_OFF_FSTAT);
	wire sel_fifo = (reg_addr == `ADCC_OFF_FIFO);
	wire sel_base = (reg_addr == `ADCC_OFF_BASE);
	wire sel_eien1 = (reg_addr == `ADCC_OFF_EIEN1);
	wire sel_eien2 = (reg_addr == `ADCC_OFF_EIEN2);
	wire sel_eistat1 = (reg_addr == `ADCC_OFF_EISTAT1);
	wire sel_eistat2 = (reg_addr == `ADCC_OFF_EISTAT2);
	wire sel_cal0 = (reg_addr == `ADCC_OFF_CAL0);
	wire sel_cal1 = (reg_addr == `ADCC_OFF_CAL1);
	wire [4:0] sel_time = {reg_addr == `ADCC_OFF_TIME4, reg_addr == `ADCC_OFF_TIME3,
		reg_addr == `ADCC_OFF_TIME2, reg_addr == `ADCC_OFF_TIME1, reg_addr == `ADCC_OFF_TIME0};
	wire [2:0] sel_cmp = {reg_addr == `ADCC_OFF_CMP6, reg_addr == `ADCC_OFF_CMP5,
		reg_addr == `ADCC_OFF_CMP4};

	// result capture: one holding word, lowest converter wins a same-cycle clash
	wire [2:0] res_acc = res_ok & fstat_q[`ADCC_ADCEN_LSB+2:`ADCC_ADCEN_LSB]
		& {3{fstat_q[`ADCC_FEN_BIT]}};
	wire take = |res_acc;
	wire [2:0] take_id = res_acc[0] ? 3'h0 : (res_acc[1] ? 3'h1 : 3'h2);
	wire fifo_read = reg_rd & sel_fifo;
	wire frdy_d = take | (frdy_q & ~fifo_read);
	wire ovf_evt = take & frdy_q & ~fifo_read;
	wire ovf_d = ovf_evt | (ovf_q & ~(reg_rd & sel_fstat));

	// early-interrupt ready: set wins over the clear-on-read
	wire [44:0] ei_set = {ei_pulse[44:3], ei_ok} & EI_MASK;
	wire [44:0] ei_clr = {{`ADCC_EI_HI_WIDTH{reg_rd & sel_eistat2}}, {32{reg_rd & sel_eistat1}}};
	wire [44:0] eistat_d = (eistat_q & ~ei_clr) | ei_set;
	wire ei_evt = |(ei_set & early_interrupt_enable_bit_q);

	wire [`ADCC_INT_WIDTH-1:0] int_evt = {ovf_evt, ei_evt, res_acc};
	wire [`ADCC_INT_WIDTH-1:0] intstat_d =
		(intstat_q & ~{`ADCC_INT_WIDTH{reg_rd & sel_intstat}}) | int_evt;
	// irq must follow a mask write in the same cycle as the mask flop itself
	wire [`ADCC_INT_WIDTH-1:0] intmask_d = (reg_wr && sel_intmask) ? reg_wdata[`ADCC_INT_WIDTH-1:0] : intmask_q;

	wire [31:0] fstat_rd = {fstat_q[31:23], frdy_q, ovf_q, 5'h00, 7'h00, frdy_q, 5'h00, fid_q};
	wire [31:0] wmask_eien1 = reg_wdata & EI_MASK[31:0];
	wire [44:0] wmask_eien2 = {reg_wdata[`ADCC_EI_HI_WIDTH-1:0], 32'h00000000} & EI_MASK;

	always_comb begin
		if (sel_ctrl3)
			reg_rdata = ctrl3_q;
		else if (sel_intstat)
			reg_rdata = {27'h0000000, intstat_q};
		else if (sel_intmask)
			reg_rdata = {27'h0000000, intmask_q};
		else if (sel_trgsns)
			reg_rdata = trgsns_q;
		else if (sel_time[0])
			reg_rdata = time_q[0];
		else if (sel_time[1])
			reg_rdata = time_q[1];
		else if (sel_time[2])
			reg_rdata = time_q[2];
		else if (sel_time[3])
			reg_rdata = time_q[3];
		else if (sel_time[4])
			reg_rdata = time_q[4];
		else if (sel_ancon)
			reg_rdata = ancon_q;
		else if (sel_cmp[0])
			reg_rdata = cmp_q[0];
		else if (sel_cmp[1])
			reg_rdata = cmp_q[1];
		else if (sel_cmp[2])
			reg_rdata = cmp_q[2];
		else if (sel_fstat)
			reg_rdata = fstat_rd;
		else if (sel_fifo)
			reg_rdata = fifo_q;
		else if (sel_base)
			reg_rdata = base_q;
		else if (sel_eien1)
			reg_rdata = early_interrupt_enable_bit_q[31:0];
		else if (sel_eien2)
			reg_rdata = {19'h00000, early_interrupt_enable_bit_q[44:32]};
		else if (sel_eistat1)
			reg_rdata = eistat_q[31:0];
		else if (sel_eistat2)
			reg_rdata = {19'h00000, eistat_q[44:32]};
		else if (sel_cal0)
			reg_rdata = cal_word0;
		else if (sel_cal1)
			reg_rdata = cal_word1;
		else
			reg_rdata = `ADCC_RESET_WORD;
	end

	// per-entry timing and comparator words share one write pattern
	generate
		for (gi = 0; gi < 5; gi++) begin : g_time
			always_ff @(posedge mclk) begin
				if (!reset_n)
					time_q[gi] <= `ADCC_RESET_WORD;
				else if (reg_wr && sel_time[gi])
					time_q[gi] <= reg_wdata & `ADCC_MASK_TIME;
			end
		end
		for (gi = 0; gi < 3; gi++) begin : g_cmp
			always_ff @(posedge mclk) begin
				if (!reset_n)
					cmp_q[gi] <= `ADCC_RESET_WORD;
				else if (reg_wr && sel_cmp[gi])
					cmp_q[gi] <= reg_wdata & `ADCC_MASK_CMP;
			end
		end
	endgenerate

	// reserved reference codes are stored as written; software keeps them out
	always_ff @(posedge mclk) begin
		if (!reset_n)
			ctrl3_q <= `ADCC_RESET_WORD;
		else if (reg_wr && sel_ctrl3)
			ctrl3_q <= reg_wdata & `ADCC_MASK_CTRL3;
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			trgsns_q <= `ADCC_RESET_WORD;
			ancon_q <= `ADCC_RESET_WORD;
			fstat_q <= `ADCC_RESET_WORD;
			base_q <= `ADCC_RESET_WORD;
			cal_word0 <= `ADCC_RESET_WORD;
			cal_word1 <= `ADCC_RESET_WORD;
			intmask_q <= 5'h00;
		end else if (reg_wr) begin
			if (sel_trgsns)
				trgsns_q <= reg_wdata & `ADCC_MASK_TRGSNS;
			if (sel_ancon)
				ancon_q <= reg_wdata & `ADCC_MASK_ANCON;
			if (sel_fstat)
				fstat_q <= reg_wdata & `ADCC_MASK_FSTAT;
			if (sel_base)
				base_q <= reg_wdata & `ADCC_MASK_BASE;
			if (sel_cal0)
				cal_word0 <= reg_wdata;
			if (sel_cal1)
				cal_word1 <= reg_wdata;
			if (sel_intmask)
				intmask_q <= reg_wdata[`ADCC_INT_WIDTH-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			early_interrupt_enable_bit_q <= 45'h000000000000;
		end else if (reg_wr && sel_eien1) begin
			early_interrupt_enable_bit_q <= {early_interrupt_enable_bit_q[44:32], wmask_eien1};
		end else if (reg_wr && sel_eien2) begin
			early_interrupt_enable_bit_q <= wmask_eien2 | {13'h0000, early_interrupt_enable_bit_q[31:0]};
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			converter_digital_enable <= 3'h0;
			reference_select <= 3'h0;
			fifo_q <= `ADCC_RESET_WORD;
			fid_q <= 3'h0;
			frdy_q <= 1'b0;
			ovf_q <= 1'b0;
			eistat_q <= 45'h000000000000;
			intstat_q <= 5'h00;
			irq <= 1'b0;
		end else begin
			if (reg_wr && sel_ctrl3) begin
				converter_digital_enable <= reg_wdata[`ADCC_DIGEN_MSB:`ADCC_DIGEN_LSB];
				reference_select <= reg_wdata[`ADCC_REFSEL_MSB:`ADCC_REFSEL_LSB];
			end
			if (take) begin
				fifo_q <= result_data;
				fid_q <= take_id;
			end
			frdy_q <= frdy_d;
			ovf_q <= ovf_d;
			eistat_q <= eistat_d;
			intstat_q <= intstat_d;
			irq <= |(intstat_d & intmask_d);
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence ctrl3_write_s;
		reg_wr && sel_ctrl3;
	endsequence

	digen_write_a: assert property (ctrl3_write_s |=>
		converter_digital_enable == $past(reg_wdata[`ADCC_DIGEN_MSB:`ADCC_DIGEN_LSB]))
		else $error("digital enables do not follow control write");
	refsel_write_a: assert property (ctrl3_write_s |=>
		reference_select == $past(reg_wdata[`ADCC_REFSEL_MSB:`ADCC_REFSEL_LSB])
		&& ctrl3_q[`ADCC_REFSEL_MSB:`ADCC_REFSEL_LSB] == reference_select)
		else $error("reference select does not follow control write");
	absent_64_a: assert property ((PINS == 64) |-> eistat_q[34:19] == 16'h0000 && early_interrupt_enable_bit_q[34:19] == 16'h0000)
		else $error("absent early bits set on smallest variant");
	absent_100_a: assert property ((PINS == 64 || PINS == 100) |-> eistat_q[42:35] == 8'h00 && early_interrupt_enable_bit_q[42:35] == 8'h00)
		else $error("absent early bits set on smaller variants");
	disabled_silent_a: assert property (!converter_digital_enable[0] && result_valid[0]
		&& !reg_rd ##1 !converter_digital_enable[0] |-> !intstat_q[0] || $past(intstat_q[0]))
		else $error("disabled converter raised a result flag");
	irq_level_a: assert property (irq == |(intstat_q & intmask_q))
		else $error("interrupt line disagrees with masked status");
	intstat_clear_a: assert property (reg_rd && sel_intstat && int_evt == 5'h00 |=> intstat_q == 5'h00)
		else $error("status read did not clear interrupt status");
endmodule

// >>> verif/adcc_core_model.sv
// stand-in for the converter cores: results, early pulses, trigger pins
// assumes the bench calls its tasks just after a rising edge of mclk
module adcc_core_model (
	input wire logic mclk,
	output logic [2:0] trig_pin,
	output logic [2:0] result_valid,
	output logic [31:0] result_data,
	output logic [44:0] ei_pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		trig_pin = 3'h0;
		result_valid = 3'h0;
		result_data = 32'h5A5A5A5A;
		ei_pulse = 45'h0;
	end
	task automatic send_result(input int i, input logic [31:0] d);
		@(posedge mclk);
		result_valid <= 3'(1 << i);
		result_data <= d;
		@(posedge mclk);
		result_valid <= 3'h0;
		// no stale word outside a valid cycle
		result_data <= ~d;
	endtask
	task automatic pulse_early(input logic [44:0] m);
		@(posedge mclk);
		ei_pulse <= m;
		@(posedge mclk);
		ei_pulse <= 45'h0;
	endtask
	task automatic set_trig(input logic [2:0] m);
		@(posedge mclk);
		trig_pin <= m;
	endtask
endmodule

// >>> verif/adc_control_register_map_test.sv
// bench for the converter control block: map, gating, interrupts, variants
// assumes hdl/ on the include path; two slaves share the bus, hready of both is the main hreadyout
`include "adcc_cfg.svh"
module adc_control_register_map_test
	import adcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [15:0] haddr = 16'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, irq, small_ready;
	logic [31:0] hrdata, small_rdata, cal_word0, cal_word1, result_data;
	logic [2:0] trig_pin, result_valid, converter_digital_enable, reference_select, conv_start;
	logic [44:0] ei_pulse;
	adcc_word_t rd, small_rd;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	int starts [3] = '{0, 0, 0};
	logic [15:0] map0 [8] = '{`ADCC_OFF_CTRL3, `ADCC_OFF_INTSTAT, `ADCC_OFF_TRGSNS, `ADCC_OFF_ANCON,
		`ADCC_OFF_FSTAT, `ADCC_OFF_CAL1, `ADCC_OFF_FIFO, `ADCC_OFF_EISTAT2};
	logic [15:0] map1 [12] = '{`ADCC_OFF_TIME1, `ADCC_OFF_TIME2, `ADCC_OFF_TIME3,
		`ADCC_OFF_TIME4, `ADCC_OFF_ANCON, `ADCC_OFF_CMP4, `ADCC_OFF_CMP5, `ADCC_OFF_CMP6,
		`ADCC_OFF_BASE, `ADCC_OFF_TRGSNS, `ADCC_OFF_INTMASK, `ADCC_OFF_FSTAT};
	logic [31:0] mask1 [12] = '{`ADCC_MASK_TIME, `ADCC_MASK_TIME, `ADCC_MASK_TIME,
		`ADCC_MASK_TIME, `ADCC_MASK_ANCON, `ADCC_MASK_CMP, `ADCC_MASK_CMP, `ADCC_MASK_CMP,
		`ADCC_MASK_BASE, `ADCC_MASK_TRGSNS, 32'h0000001F, `ADCC_MASK_FSTAT};

	always #5 mclk = ~mclk;

	adcc_top u_adcc_top (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .trig_pin, .result_valid, .result_data, .ei_pulse, .converter_digital_enable,
		.reference_select, .conv_start, .cal_word0, .cal_word1, .irq);
	// small variant rides the same bus; its data is only observed
	adcc_top #(.PINS(64)) u_adcc_top_small (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout(small_ready), .hresp(), .hrdata(small_rdata), .trig_pin, .result_valid,
		.result_data, .ei_pulse, .converter_digital_enable(), .reference_select(), .conv_start(), .cal_word0(),
		.cal_word1(), .irq());
	adcc_core_model u_adcc_core_model (.mclk, .trig_pin, .result_valid, .result_data, .ei_pulse);

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// address phase held until hready seen high, then data phase likewise
	task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		rd = hrdata;
		small_rd = small_rdata;
		check(hresp, 32'h0, "hresp");
	endtask

	task automatic rchk(input logic [15:0] a, input logic [31:0] e, input string what);
		bus(1'b0, a, 32'h0);
		check(rd, e, what);
	endtask

	always @(posedge mclk) begin
		cycles++;
		for (int i = 0; i < 3; i++)
			if (conv_start[i] === 1'b1)
				starts[i]++;
		if (cycles == 20000) begin
			fails++;
			$display("MISMATCH at %0t: timeout", $time);
			tally_and_finish();
		end
	end

	initial begin
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		foreach (map0[k])
			rchk(map0[k], 32'h0, "reset value");
		bus(1'b1, 16'h0200, 32'hFFFFFFFF);
		rchk(16'h0200, 32'h0, "unmapped");
		bus(1'b1, `ADCC_OFF_TIME0, 32'hFFFFFFFF);
		rchk(`ADCC_OFF_TIME0, `ADCC_MASK_TIME, "timing");
		bus(1'b1, `ADCC_OFF_EISTAT1, 32'hFFFFFFFF);
		rchk(`ADCC_OFF_EISTAT1, 32'h0, "read-only");
		foreach (map1[k]) begin
			bus(1'b1, map1[k], 32'hFFFFFFFF);
			rchk(map1[k], mask1[k], "writable bits");
		end
		// a byte-sized transfer is ignored and gets no wait state
		hsize <= 3'h0;
		bus(1'b1, `ADCC_OFF_BASE, 32'h0000A5A5);
		hsize <= `ADCC_HSIZE_WORD;
		rchk(`ADCC_OFF_BASE, `ADCC_MASK_BASE, "sized write refused");
		$display("test map done");
		// calibration goes in before the converter digital enables
		bus(1'b1, `ADCC_OFF_CAL0, 32'h12345678);
		bus(1'b1, `ADCC_OFF_CAL1, 32'h9ABCDEF0);
		check(cal_word0, 32'h12345678, "cal0");
		check(cal_word1, 32'h9ABCDEF0, "cal1");
		// only the non-reserved codes are ever written
		for (int c = 1; c < 4; c++) begin
			bus(1'b1, `ADCC_OFF_CTRL3, 32'h00070000 | (c << 13));
			rchk(`ADCC_OFF_CTRL3, 32'h00070000 | (c << 13), "control");
			check(reference_select, 3'(c), "refsel");
			check(converter_digital_enable, 3'h7, "enables");
		end
		bus(1'b1, `ADCC_OFF_EIEN1, 32'hFFFFFFFF);
		rchk(`ADCC_OFF_EIEN1, 32'hFFFFFFFF, "eien1");
		check(small_rd, 32'h0007FFFF, "small eien1");
		bus(1'b1, `ADCC_OFF_EIEN2, 32'hFFFFFFFF);
		rchk(`ADCC_OFF_EIEN2, 32'h00001FFF, "eien2");
		check(small_rd, 32'h00001800, "small eien2");
		$display("test control done");
		bus(1'b1, `ADCC_OFF_CTRL3, 32'h00062000);
		check(converter_digital_enable, 3'h6, "enables");
		bus(1'b1, `ADCC_OFF_FSTAT, 32'h83000000);
		bus(1'b1, `ADCC_OFF_INTMASK, 32'h1F);
		u_adcc_core_model.send_result(0, 32'h111);
		bus(1'b0, `ADCC_OFF_FSTAT, 32'h0);
		check(rd & 32'h00600000, 32'h0, "gated result");
		check(irq, 1'b0, "gated irq");
		u_adcc_core_model.send_result(1, 32'hABC);
		repeat (2) @(posedge mclk);
		check(irq, 1'b1, "irq");
		rchk(`ADCC_OFF_FIFO, 32'hABC, "fifo");
		rchk(`ADCC_OFF_INTSTAT, 32'h2, "status");
		repeat (2) @(posedge mclk);
		check(irq, 1'b0, "irq clear");
		bus(1'b1, `ADCC_OFF_INTMASK, 32'h0);
		u_adcc_core_model.send_result(1, 32'h1);
		u_adcc_core_model.send_result(1, 32'h2);
		repeat (2) @(posedge mclk);
		check(irq, 1'b0, "masked irq");
		bus(1'b0, `ADCC_OFF_FSTAT, 32'h0);
		check(rd & 32'h00600000, 32'h00600000, "overrun");
		rchk(`ADCC_OFF_INTSTAT, 32'h12, "status overrun");
		// input 0 belongs to the disabled converter
		u_adcc_core_model.pulse_early(45'h21);
		rchk(`ADCC_OFF_EISTAT1, 32'h20, "early ready");
		rchk(`ADCC_OFF_EISTAT1, 32'h0, "early clear");
		rchk(`ADCC_OFF_INTSTAT, 32'h8, "early status");
		$display("test results done");
		bus(1'b1, `ADCC_OFF_TRGSNS, 32'h0);
		u_adcc_core_model.set_trig(3'h3);
		repeat (10) @(posedge mclk);
		check(starts[1], 1, "edge start");
		check(starts[0], 0, "gated start");
		bus(1'b1, `ADCC_OFF_TRGSNS, 32'h2);
		repeat (6) @(posedge mclk);
		check(conv_start[1], 1'b1, "level start");
		check(conv_start[0], 1'b0, "gated level");
		u_adcc_core_model.set_trig(3'h0);
		$display("test triggers done");
		reset_n <= 1'b0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		rchk(`ADCC_OFF_CTRL3, 32'h0, "control after reset");
		rchk(`ADCC_OFF_EIEN1, 32'h0, "eien1 after reset");
		check(converter_digital_enable, 3'h0, "enables after reset");
		check(irq, 1'b0, "irq after reset");
		$display("test reset done");
		tally_and_finish();
	end
endmodule
